// file: design/bus_port_pin_function_control.sv
// APB register block steering an address/timer port, bus-control pins and
// pull-up enables. Assumes pins come from pads outside the pclk domain and
// bus/timer signals from logic on pclk.
//
// What this block does
// - Sixteen address/timer pins, direction per pin
// - Output pins drive latch bits, latch resets zero
// - Direction 0 output, 1 input, resets ones
// - Whole registers taken as 16-bit quantities
// - Byte halves separately writable via strobes
// - Lower pins: mode 1 drives address line
// - Alt-enable reset zeros single-chip, ones ROMless
// - Upper pins: select address or capture input
// - Function select upper byte only, resets zero
// - Lower function-select half ignores writes
// - Pull-up bit 1 connects, resets zero
// - Wait/clock mode bits, reset 00H or 01H
// - Chip-select mode bits, reset 00H or 07H
// - Strobe mode bits 0, 1, 4
// - Upper-address mode 0 means general pin
// - Bus-control pins individually input or output
// - Upper-address mode 1 drives lines 16-18
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module bus_port_pin_function_control
  import pin_function_pkg::*;
#(
  parameter int          ADDR_W              = 16,
  parameter logic [7:0]  STROBE_ROMLESS      = 8'h13
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // Boot strap: high selects ROMless mode
  input  wire logic                        romless_strap,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ADDR_W-1:0]           paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  // Address/timer port pins
  input  wire logic [pin_function_pkg::PORT_W-1:0]   port_pin_in,
  output logic [pin_function_pkg::PORT_W-1:0]        port_pin_out,
  output logic [pin_function_pkg::PORT_W-1:0]        port_pin_oe,
  // Alternate sources and sinks for the address/timer port
  input  wire logic [pin_function_pkg::PORT_W-1:0]   address_line_output,
  output logic [pin_function_pkg::CAP_W-1:0]         timer_capture_input,
  // Bus-control pins: 0 wait, 1 clock, 4:2 chip select, 7:5 strobes, 10:8 A16-18
  input  wire logic [pin_function_pkg::BUS_PINS-1:0] bus_pin_in,
  output logic [pin_function_pkg::BUS_PINS-1:0]      bus_pin_out,
  output logic [pin_function_pkg::BUS_PINS-1:0]      bus_pin_oe,
  // Bus controller signals routed to and from those pins
  input  wire logic                                  clock_output_pin,
  input  wire logic [pin_function_pkg::CS_W-1:0]     chip_select_output,
  input  wire logic                                  lower_write_strobe,
  input  wire logic                                  upper_write_strobe,
  input  wire logic                                  read_strobe,
  input  wire logic [pin_function_pkg::HI_ADR_W-1:0] upper_address_output,
  output logic                                       bus_wait_input,
  // Pull-up enables of the serial/timer port
  output logic [pin_function_pkg::PULL_W-1:0]        pullup_enable
);
  import pin_function_pkg::*;

  typedef struct packed {
    // Registers software sees
    logic [PORT_W-1:0]   latch;
    logic [PORT_W-1:0]   dir;
    logic [PORT_W-1:0]   alt;
    logic [PORT_W-1:0]   fsel;
    logic [7:0]          pull;
    logic [7:0]          cm_mode;
    logic [7:0]          cs_mode;
    logic [7:0]          ct_mode;
    logic [7:0]          dh_mode;
    logic [BUS_PINS-1:0] bus_latch;
    logic [BUS_PINS-1:0] bus_dir;

    // Pad and strap synchronisers
    logic [PORT_W-1:0]   p_s1;
    logic [PORT_W-1:0]   p_s2;
    logic [PORT_W-1:0]   p_s3;
    logic [PORT_W-1:0]   p_lvl;
    logic [BUS_PINS-1:0] b_s1;
    logic [BUS_PINS-1:0] b_s2;
    logic [BUS_PINS-1:0] b_s3;
    logic [BUS_PINS-1:0] b_lvl;
    logic                st_s1;
    logic                st_s2;
    logic                st_s3;
    logic                st_lvl;

    // Strap load and bus answer
    logic [2:0]          init_cnt;
    logic                init_done;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;

    // Flopped copies of the outputs
    logic [PORT_W-1:0]   p_out;
    logic [PORT_W-1:0]   p_oe;
    logic [CAP_W-1:0]    cap;
    logic [BUS_PINS-1:0] b_out;
    logic [BUS_PINS-1:0] b_oe;
    logic                wait_in;
    logic [PULL_W-1:0]   pull_en;
  } state_s;

  state_s q;
  state_s d;

  // Low index bits only; upper bits alias
  function automatic reg_sel_e decode(input logic [ADDR_W-1:0] a);
    logic [IDX_DEC_W-1:0] idx;
    idx = a[ADDR_LSB +: IDX_DEC_W];
    if      (idx == IDX_PULLUP[IDX_DEC_W-1:0])    decode = SEL_PULLUP;
    else if (idx == IDX_DH_MODE[IDX_DEC_W-1:0])   decode = SEL_DH;
    else if (idx == IDX_CS_MODE[IDX_DEC_W-1:0])   decode = SEL_CS;
    else if (idx == IDX_CT_MODE[IDX_DEC_W-1:0])   decode = SEL_CT;
    else if (idx == IDX_CM_MODE[IDX_DEC_W-1:0])   decode = SEL_CM;
    else if (idx == IDX_LATCH[IDX_DEC_W-1:0])     decode = SEL_LATCH;
    else if (idx == IDX_DIR[IDX_DEC_W-1:0])       decode = SEL_DIR;
    else if (idx == IDX_ALT[IDX_DEC_W-1:0])       decode = SEL_ALT;
    else if (idx == IDX_FSEL[IDX_DEC_W-1:0])      decode = SEL_FSEL;
    else if (idx == IDX_BUS_LATCH[IDX_DEC_W-1:0]) decode = SEL_BUS_LATCH;
    else if (idx == IDX_BUS_DIR[IDX_DEC_W-1:0])   decode = SEL_BUS_DIR;
    else                                          decode = SEL_NONE;
  endfunction : decode

  // Byte lanes 0 and 1 update independently of each other
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  strb);
    merge16[7:0]  = strb[0] ? wd[7:0]  : old[7:0];
    merge16[15:8] = strb[1] ? wd[15:8] : old[15:8];
  endfunction : merge16

  // Byte registers sit in lane 0
  function automatic logic [7:0] merge8(input logic [7:0]  old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  strb,
                                        input logic [7:0]  mask);
    merge8 = strb[0] ? (wd[7:0] & mask) : old;
  endfunction : merge8

  // Input pins read back as pin level, output pins as latch
  function automatic logic [15:0] port_read(input logic [15:0] lat,
                                            input logic [15:0] dr,
                                            input logic [15:0] lvl);
    port_read = (dr & lvl) | (~dr & lat);
  endfunction : port_read

  reg_sel_e            sel;
  logic                access;
  logic                wr;
  logic [31:0]         rdata;
  logic [BUS_PINS-1:0] bus_alt;
  logic [BUS_PINS-1:0] bus_val;
  // Bus-pin registers widened for lane merging
  logic [15:0]         bus_wide;

  always_comb begin
    d       = q;
    sel     = decode(paddr);
    access  = psel & penable & q.pready;
    wr      = access & pwrite;
    rdata   = 32'h0000_0000;
    bus_alt = {BUS_PINS{1'b0}};
    bus_val = {BUS_PINS{1'b0}};
    bus_wide = 16'h0000;

    // Three-stage pin synchronisers; a change counts once stages 2 and 3 agree
    // so a one-cycle pad glitch never reaches software
    d.p_s1  = port_pin_in;
    d.p_s2  = q.p_s1;
    d.p_s3  = q.p_s2;
    d.p_lvl = (~(q.p_s2 ^ q.p_s3) & q.p_s3) | ((q.p_s2 ^ q.p_s3) & q.p_lvl);
    d.b_s1  = bus_pin_in;
    d.b_s2  = q.b_s1;
    d.b_s3  = q.b_s2;
    d.b_lvl = (~(q.b_s2 ^ q.b_s3) & q.b_s3) | ((q.b_s2 ^ q.b_s3) & q.b_lvl);
    d.st_s1 = romless_strap;
    d.st_s2 = q.st_s1;
    d.st_s3 = q.st_s2;
    if (q.st_s2 == q.st_s3) begin
      d.st_lvl = q.st_s3;
    end

    // Mode controls load from the strap once it has settled after reset
    // Requests stall meanwhile; no read sees a half-set mode
    if (!q.init_done) begin
      if (q.init_cnt == INIT_CYCLES) begin
        d.init_done = 1'b1;
        if (q.st_lvl) begin
          d.alt     = ALT_ROMLESS;
          d.cm_mode = CM_ROMLESS;
          d.cs_mode = CS_ROMLESS;
          d.ct_mode = STROBE_ROMLESS & CT_MASK;
          d.dh_mode = DH_ROMLESS;
        end else begin
          d.alt     = ALT_SINGLE;
          d.cm_mode = MODE_SINGLE;
          d.cs_mode = MODE_SINGLE;
          d.ct_mode = MODE_SINGLE;
          d.dh_mode = MODE_SINGLE;
        end
      end else begin
        d.init_cnt = q.init_cnt + 3'h1;
      end
    end

    // Register writes, per byte lane
    // They land at the edge where pready is sampled high
    if (wr) begin
      case (sel)
        SEL_LATCH:     d.latch = merge16(q.latch, pwdata, pstrb);
        SEL_DIR:       d.dir   = merge16(q.dir, pwdata, pstrb);
        SEL_ALT:       d.alt   = merge16(q.alt, pwdata, pstrb);
        // Lower half is not implemented, so its writes vanish
        SEL_FSEL:      d.fsel  = merge16(q.fsel, pwdata, pstrb)
                                 & FSEL_MASK;
        SEL_PULLUP:    d.pull  = merge8(q.pull, pwdata, pstrb,
                                        PULL_MASK);
        SEL_CM:        d.cm_mode = merge8(q.cm_mode, pwdata, pstrb,
                                          CM_MASK);
        SEL_CS:        d.cs_mode = merge8(q.cs_mode, pwdata, pstrb,
                                          CS_MASK);
        SEL_CT:        d.ct_mode = merge8(q.ct_mode, pwdata, pstrb,
                                          CT_MASK);
        SEL_DH:        d.dh_mode = merge8(q.dh_mode, pwdata, pstrb,
                                          DH_MASK);
        SEL_BUS_LATCH: begin
          bus_wide    = merge16({5'h00, q.bus_latch}, pwdata, pstrb);
          d.bus_latch = bus_wide[BUS_PINS-1:0];
        end
        SEL_BUS_DIR: begin
          bus_wide  = merge16({5'h00, q.bus_dir}, pwdata, pstrb);
          d.bus_dir = bus_wide[BUS_PINS-1:0];
        end
        default: begin
        end
      endcase
    end

    // Read data, presented with pready in the access phase
    // Unmapped indices read zero; pslverr flags them
    case (sel)
      SEL_LATCH:     rdata[15:0] = port_read(q.latch, q.dir, q.p_lvl);
      SEL_DIR:       rdata[15:0] = q.dir;
      SEL_ALT:       rdata[15:0] = q.alt;
      SEL_FSEL:      rdata[15:0] = q.fsel & FSEL_MASK;
      SEL_PULLUP:    rdata[7:0]  = q.pull;
      SEL_CM:        rdata[7:0]  = q.cm_mode;
      SEL_CS:        rdata[7:0]  = q.cs_mode;
      SEL_CT:        rdata[7:0]  = q.ct_mode;
      SEL_DH:        rdata[7:0]  = q.dh_mode;
      SEL_BUS_LATCH: rdata[15:0] = port_read({5'h00, q.bus_latch},
                                             {5'h00, q.bus_dir},
                                             {5'h00, q.b_lvl});
      SEL_BUS_DIR:   rdata[BUS_PINS-1:0] = q.bus_dir;
      default:       rdata = 32'h0000_0000;
    endcase

    // One-cycle answer; held off until mode controls have loaded
    d.pready  = psel & ~q.pready & q.init_done;
    d.prdata  = (psel & ~q.pready & ~pwrite) ? rdata : 32'h0000_0000;
    d.pslverr = psel & ~q.pready & q.init_done & (sel == SEL_NONE);

    // Address/timer port pin control
    // Flopped enables cannot glitch, at one cycle of lag
    for (int i = 0; i < PORT_W; i++) begin
      if (q.alt[i] && (i < LOW_W || !q.fsel[i])) begin
        d.p_out[i] = address_line_output[i];
        d.p_oe[i]  = 1'b1;
      end else if (q.alt[i]) begin
        d.p_out[i] = 1'b0;
        d.p_oe[i]  = 1'b0;
      end else begin
        d.p_out[i] = q.latch[i];
        d.p_oe[i]  = ~q.dir[i];
      end
    end
    // Capture sees the synchronised level only
    for (int j = 0; j < CAP_W; j++) begin
      d.cap[j] = q.alt[LOW_W+j] & q.fsel[LOW_W+j] & q.p_lvl[LOW_W+j];
    end

    // Bus-control pins: alternate where the mode bit is set
    // Wait is input-only, so its mode releases the pad
    bus_alt = {q.dh_mode[HI_ADR_W-1:0], q.ct_mode[CT_RD_BIT],
               q.ct_mode[CT_WRH_BIT], q.ct_mode[CT_WRL_BIT],
               q.cs_mode[CS_W-1:0], q.cm_mode[CM_CLK_BIT],
               q.cm_mode[CM_WAIT_BIT]};
    bus_val = {upper_address_output, read_strobe, upper_write_strobe,
               lower_write_strobe, chip_select_output,
               clock_output_pin, 1'b0};
    d.b_out = (bus_alt & bus_val) | (~bus_alt & q.bus_latch);
    d.b_oe  = (bus_alt & BUS_DRIVE_MASK)
            | (~bus_alt & ~q.bus_dir);
    d.wait_in = q.cm_mode[CM_WAIT_BIT] & q.b_lvl[0];

    d.pull_en = q.pull[PULL_W-1:0];
  end

  // Modes reset single-chip; the strap loads them later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.latch     <= LATCH_RST;
      q.dir       <= DIR_RST;
      q.alt       <= ALT_SINGLE;
      q.fsel      <= FSEL_RST;
      q.pull      <= PULL_RST;
      q.cm_mode   <= MODE_SINGLE;
      q.cs_mode   <= MODE_SINGLE;
      q.ct_mode   <= MODE_SINGLE;
      q.dh_mode   <= MODE_SINGLE;
      q.bus_latch <= BUS_LATCH_RST;
      q.bus_dir   <= BUS_DIR_RST;
      q.p_s1      <= '0;
      q.p_s2      <= '0;
      q.p_s3      <= '0;
      q.p_lvl     <= '0;
      q.b_s1      <= '0;
      q.b_s2      <= '0;
      q.b_s3      <= '0;
      q.b_lvl     <= '0;
      q.st_s1     <= 1'b0;
      q.st_s2     <= 1'b0;
      q.st_s3     <= 1'b0;
      q.st_lvl    <= 1'b0;
      q.init_cnt  <= 3'h0;
      q.init_done <= 1'b0;
      q.pready    <= 1'b0;
      q.pslverr   <= 1'b0;
      q.prdata    <= 32'h0000_0000;
      q.p_out     <= '0;
      q.p_oe      <= '0;
      q.cap       <= '0;
      q.b_out     <= '0;
      q.b_oe      <= '0;
      q.wait_in   <= 1'b0;
      q.pull_en   <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from flip-flops
  assign pready              = q.pready;
  assign prdata              = q.prdata;
  assign pslverr             = q.pslverr;
  assign port_pin_out        = q.p_out;
  assign port_pin_oe         = q.p_oe;
  assign timer_capture_input = q.cap;
  assign bus_pin_out         = q.b_out;
  assign bus_pin_oe          = q.b_oe;
  assign bus_wait_input      = q.wait_in;
  assign pullup_enable       = q.pull_en;

endmodule : bus_port_pin_function_control

`default_nettype wire

// file: design/pin_function_pkg.sv
// Constants, register map and reset values for the pin function block.
// Assumes an APB master with 32-bit data and byte strobes (pstrb).
package pin_function_pkg;

  // Widths
  localparam int PORT_W   = 16;
  localparam int LOW_W    = 8;
  localparam int CAP_W    = 8;
  localparam int PULL_W   = 7;
  localparam int BUS_PINS = 11;
  localparam int HI_ADR_W = 3;
  localparam int CS_W     = 3;

  // Register indices; byte address is four times the index
  localparam logic [31:0] IDX_PULLUP     = 32'h0fff_fc48;
  localparam logic [31:0] IDX_DH_MODE    = 32'hffff_f046;
  localparam logic [31:0] IDX_CS_MODE    = 32'hffff_f048;
  localparam logic [31:0] IDX_CT_MODE    = 32'hffff_f04a;
  localparam logic [31:0] IDX_LATCH      = 32'hffff_f412;
  localparam logic [31:0] IDX_DIR        = 32'hffff_f432;
  localparam logic [31:0] IDX_ALT        = 32'hffff_f452;
  localparam logic [31:0] IDX_FSEL       = 32'hffff_f472;
  localparam logic [31:0] IDX_CM_MODE    = 32'hffff_f04c;
  localparam logic [31:0] IDX_BUS_LATCH  = 32'hffff_f04e;
  localparam logic [31:0] IDX_BUS_DIR    = 32'hffff_f050;

  // Decoding uses these index bits, taken from paddr above the word bits
  localparam int IDX_DEC_W = 12;
  localparam int ADDR_LSB  = 2;

  // Reset values
  localparam logic [15:0] LATCH_RST       = 16'h0000;
  localparam logic [15:0] DIR_RST         = 16'hffff;
  localparam logic [15:0] ALT_SINGLE      = 16'h0000;
  localparam logic [15:0] ALT_ROMLESS     = 16'hffff;
  localparam logic [15:0] FSEL_RST        = 16'h0000;
  localparam logic [7:0]  PULL_RST        = 8'h00;
  localparam logic [7:0]  MODE_SINGLE     = 8'h00;
  localparam logic [7:0]  CM_ROMLESS      = 8'h01;
  localparam logic [7:0]  CS_ROMLESS      = 8'h07;
  localparam logic [7:0]  DH_ROMLESS      = 8'h07;
  localparam logic [10:0] BUS_LATCH_RST   = 11'h000;
  localparam logic [10:0] BUS_DIR_RST     = 11'h7ff;

  // Implemented bits
  localparam logic [15:0] FSEL_MASK = 16'hff00;
  localparam logic [7:0]  PULL_MASK = 8'h7f;
  localparam logic [7:0]  CM_MASK   = 8'h03;
  localparam logic [7:0]  CS_MASK   = 8'h07;
  localparam logic [7:0]  CT_MASK   = 8'h13;
  localparam logic [7:0]  DH_MASK   = 8'h07;

  // Mode bit positions
  localparam int CM_WAIT_BIT = 0;
  localparam int CM_CLK_BIT  = 1;
  localparam int CT_WRL_BIT  = 0;
  localparam int CT_WRH_BIT  = 1;
  localparam int CT_RD_BIT   = 4;

  // Bus-control pins that the alternate function drives (wait is input)
  localparam logic [10:0] BUS_DRIVE_MASK = 11'h7fe;

  // Strap settling before mode registers load
  localparam logic [2:0] INIT_CYCLES = 3'h5;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_PULLUP, SEL_DH, SEL_CS, SEL_CT, SEL_CM,
    SEL_LATCH, SEL_DIR, SEL_ALT, SEL_FSEL, SEL_BUS_LATCH, SEL_BUS_DIR
  } reg_sel_e;

endpackage : pin_function_pkg

// file: verification/pin_function_checker.sv
// Assertion checker for the pin function block, bound to its top module.
// Assumes one pclk domain and the register map of the package.
`timescale 1ns/100ps
`default_nettype none
module pin_function_checker
  import pin_function_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // APB
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_W-1:0]     paddr,
  input wire logic                  pready,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  // Pins and routed signals
  input wire logic [PORT_W-1:0]     port_pin_oe,
  input wire logic [CAP_W-1:0]      timer_capture_input,
  input wire logic [BUS_PINS-1:0]   bus_pin_oe,
  input wire logic                  bus_wait_input,
  input wire logic [PULL_W-1:0]     pullup_enable
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [11:0] idx;
  logic        rd_ok;
  assign idx = paddr[13:2];
  assign rd_ok = pready && !pwrite;
  chk_ready_phase:
    assert property (pready |-> psel && penable) else $error("stray ready");
  chk_ready_single:
    assert property (pready |=> !pready) else $error("ready too long");
  chk_answer_bound:
    assert property (psel && !penable |-> ##[1:12] pready)
      else $error("no answer");
  chk_err_quiet:
    assert property (pslverr || (pready && pwrite) |-> prdata == 32'h0)
      else $error("data on error or write");
  chk_fsel_low_zero:
    assert property (rd_ok && idx == IDX_FSEL[11:0] |-> prdata[7:0] == 8'h00)
      else $error("select low half not zero");
  chk_pull_top_zero:
    assert property (rd_ok && idx == IDX_PULLUP[11:0] |-> prdata[31:7] == 0)
      else $error("pull-up upper bits set");
  chk_capture_undriven:
    assert property ((timer_capture_input & port_pin_oe[15:8]) == 8'h00)
      else $error("capture pin driven");
  chk_wait_undriven:
    assert property (bus_wait_input |-> !bus_pin_oe[0])
      else $error("wait pin driven");
  chk_reset_quiet:
    assert property ($rose(presetn) |-> (port_pin_oe == 16'h0000 && !pready)[*5])
      else $error("pins or ready active after reset");
  chk_pull_reset:
    assert property ($rose(presetn) |-> pullup_enable == 7'h00)
      else $error("pull-up set after reset");
  cover property (pready && pwrite);
  cover property (rd_ok && idx == IDX_FSEL[11:0]);
  cover property (pslverr);
  cover property (timer_capture_input != 8'h00);
endmodule : pin_function_checker

bind bus_port_pin_function_control pin_function_checker #(
  .ADDR_W(ADDR_W)
) checker_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .prdata,
  .pslverr, .port_pin_oe, .timer_capture_input, .bus_pin_oe,
  .bus_wait_input, .pullup_enable
);
`default_nettype wire

// file: verification/pin_pad_model.sv
// Pad and far-side model: resolves each pin from the block and the board.
// Assumes the block's drive wins; an undriven pin floats, toggling.
`timescale 1ns/100ps
`default_nettype none
module pin_pad_model #(
  parameter int W = 16
) (
  // Clock
  input  wire logic         pclk,
  // Block side
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  // Board side
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  // Level seen back by the block
  output logic [W-1:0]      pin_in
);
  logic [W-1:0] last_q;
  // No pulls here, so a released pin must not hold its old level
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : ~last_q[i];
    end
  end
  always_ff @(posedge pclk) begin
    last_q <= pin_in;
  end
endmodule : pin_pad_model
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the pin function block, driven over APB.
// Assumes the pad model on both pin groups and the package constants.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pin_function_pkg::*;
  localparam logic [7:0] CT_RL = 8'h13;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        romless_strap = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic        pready, pslverr, bus_wait_input;
  logic [31:0] prdata;
  logic [15:0] port_pin_in, port_pin_out, port_pin_oe;
  logic [15:0] address_line_output = 16'h1234;
  logic [15:0] p_ext = 16'h0000;
  logic [15:0] p_ext_en = 16'hffff;
  logic [7:0]  timer_capture_input;
  logic [10:0] bus_pin_in, bus_pin_out, bus_pin_oe;
  logic [10:0] b_ext = 11'h001;
  logic        clock_output_pin = 1'b0;
  logic [2:0]  chip_select_output = 3'h0;
  logic        lower_write_strobe = 1'b0;
  logic        upper_write_strobe = 1'b0;
  logic        read_strobe = 1'b0;
  logic [2:0]  upper_address_output = 3'h0;
  logic [6:0]  pullup_enable;
  int          err_count = 0;
  int          n_checks = 0;
  always #2.5 pclk = ~pclk;
  bus_port_pin_function_control #(.STROBE_ROMLESS(CT_RL)) uut (
    .pclk, .presetn, .romless_strap, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .port_pin_in,
    .port_pin_out, .port_pin_oe, .address_line_output,
    .timer_capture_input, .bus_pin_in, .bus_pin_out, .bus_pin_oe,
    .clock_output_pin, .chip_select_output, .lower_write_strobe,
    .upper_write_strobe, .read_strobe, .upper_address_output,
    .bus_wait_input, .pullup_enable);
  pin_pad_model #(.W(16)) port_pads (.pclk, .pin_out(port_pin_out),
    .pin_oe(port_pin_oe), .ext_val(p_ext), .ext_en(p_ext_en),
    .pin_in(port_pin_in));
  pin_pad_model #(.W(11)) bus_pads (.pclk, .pin_out(bus_pin_out),
    .pin_oe(bus_pin_oe), .ext_val(b_ext), .ext_en(11'h001),
    .pin_in(bus_pin_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  // Called just after an edge; holds the request until ready is sampled
  task automatic apb(input logic w, input logic [31:0] ix,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, ix[11:0], 2'b00};
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    check({31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [31:0] ix, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, ix, d, s, rd, er);
  endtask : wr
  task automatic rdchk(input logic [31:0] ix, input logic [31:0] exp);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, ix, 32'h0, 4'h0, rd, er);
    check(rd, exp);
  endtask : rdchk
  task automatic t_reset(input logic rl);
    logic [15:0] m;
    m = {16{rl}};
    presetn <= 1'b0;
    romless_strap <= rl;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
    rdchk(IDX_LATCH, {16'h0, m & address_line_output});
    rdchk(IDX_DIR, 32'h0000_ffff);
    rdchk(IDX_ALT, {16'h0, m});
    rdchk(IDX_FSEL, 32'h0);
    rdchk(IDX_PULLUP, 32'h0);
    rdchk(IDX_CM_MODE, {24'h0, (rl ? CM_ROMLESS : MODE_SINGLE)});
    rdchk(IDX_CS_MODE, {24'h0, (rl ? CS_ROMLESS : MODE_SINGLE)});
    rdchk(IDX_CT_MODE, {24'h0, (rl ? CT_RL : MODE_SINGLE)});
    rdchk(IDX_DH_MODE, {24'h0, (rl ? DH_ROMLESS : MODE_SINGLE)});
    check({16'h0, port_pin_oe}, {16'h0, m});
    check({21'h0, bus_pin_oe}, rl ? 32'h7fc : 32'h0);
  endtask : t_reset
  task automatic t_port_io;
    p_ext_en <= 16'hff00;
    p_ext <= 16'h5a00;
    wr(IDX_DIR, 32'h0, 4'b0001);
    wr(IDX_LATCH, 32'h0000_c3a5, 4'b0011);
    repeat (6) @(posedge pclk);
    check({16'h0, port_pin_oe}, 32'h00ff);
    check({24'h0, port_pin_out[7:0]}, 32'ha5);
    rdchk(IDX_DIR, 32'h0000_ff00);
    rdchk(IDX_LATCH, 32'h0000_5aa5);
    p_ext_en <= 16'h0f00;
    wr(IDX_DIR, 32'h0000_0f00, 4'b0010);
    repeat (6) @(posedge pclk);
    check({16'h0, port_pin_oe}, 32'hf0ff);
    rdchk(IDX_LATCH, 32'h0000_caa5);
  endtask : t_port_io
  task automatic t_addr;
    wr(IDX_FSEL, 32'hffff_ffff, 4'b1111);
    rdchk(IDX_FSEL, 32'h0000_ff00);
    wr(IDX_FSEL, 32'h0, 4'b0001);
    rdchk(IDX_FSEL, 32'h0000_ff00);
    address_line_output <= 16'h3c96;
    p_ext_en <= 16'h0000;
    wr(IDX_FSEL, 32'h0, 4'b0011);
    wr(IDX_ALT, 32'h0000_ffff, 4'b0011);
    repeat (3) @(posedge pclk);
    check({16'h0, port_pin_oe}, 32'hffff);
    check({16'h0, port_pin_out}, 32'h3c96);
    wr(IDX_FSEL, 32'h0000_ff00, 4'b0010);
    p_ext_en <= 16'hff00;
    p_ext <= 16'ha500;
    repeat (6) @(posedge pclk);
    check({24'h0, timer_capture_input}, 32'ha5);
    check({16'h0, port_pin_oe}, 32'h00ff);
    check({24'h0, port_pin_out[7:0]}, 32'h96);
  endtask : t_addr
  task automatic t_bus;
    clock_output_pin <= 1'b1;
    chip_select_output <= 3'b101;
    lower_write_strobe <= 1'b1;
    read_strobe <= 1'b1;
    upper_address_output <= 3'b110;
    wr(IDX_CM_MODE, 32'h3, 4'b0001);
    wr(IDX_CS_MODE, 32'h7, 4'b0001);
    wr(IDX_CT_MODE, 32'hff, 4'b0001);
    wr(IDX_DH_MODE, 32'h7, 4'b0001);
    repeat (6) @(posedge pclk);
    check({21'h0, bus_pin_oe}, 32'h7fe);
    check({21'h0, bus_pin_out & 11'h7fe}, 32'h6b6);
    check({31'h0, bus_wait_input}, 32'h1);
    rdchk(IDX_CT_MODE, 32'h13);
    wr(IDX_CM_MODE, 32'h0, 4'b0001);
    wr(IDX_CS_MODE, 32'h0, 4'b0001);
    wr(IDX_CT_MODE, 32'h0, 4'b0001);
    wr(IDX_DH_MODE, 32'h0, 4'b0001);
    wr(IDX_BUS_DIR, 32'h1, 4'b0011);
    wr(IDX_BUS_LATCH, 32'h555, 4'b0011);
    repeat (3) @(posedge pclk);
    check({21'h0, bus_pin_oe}, 32'h7fe);
    check({21'h0, bus_pin_out & 11'h7fe}, 32'h554);
    check({31'h0, bus_wait_input}, 32'h0);
  endtask : t_bus
  task automatic t_pull_err;
    logic [31:0] rd;
    logic        er;
    wr(IDX_PULLUP, 32'hff, 4'b0001);
    rdchk(IDX_PULLUP, 32'h7f);
    check({25'h0, pullup_enable}, 32'h7f);
    apb(1'b0, 32'h100, 32'h0, 4'h0, rd, er);
    check({er, rd[30:0]}, 32'h8000_0000);
  endtask : t_pull_err
  initial begin
    t_reset(1'b1);
    t_reset(1'b0);
    t_port_io();
    t_addr();
    t_bus();
    t_pull_err();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
